// [bench/afe_model.sv]
// Converter front end and pin pull-up seen by the sensor logic.
module afe_model (
  input  logic        aclk,
  input  logic [11:0] amb_set,
  input  logic [7:0]  prox_set,
  output logic [11:0] ambient_adc_code,
  output logic [7:0]  prox_adc_code,
  input  logic        irq_n_o,
  input  logic        irq_n_oe,
  output logic        irq_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Codes leave the converters registered, so they change only on the rising clock edge.
  always_ff @(posedge aclk) begin
    ambient_adc_code <= amb_set;
    prox_adc_code    <= prox_set;
  end
  // The pin has a pull-up, so a released driver reads as high.
  assign irq_pin = irq_n_oe ? 1'b1 : irq_n_o;
endmodule

// [bench/sensor_props.sv]
module sensor_props #(
  parameter longint LED_CYC = 5
) (
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic        emitter_driver_sink,
  input logic        irq_n_o,
  input logic        irq_n_oe
);
  // ==========================================================================
  // Helper: length of the current emitter pulse in cycles.
  // ==========================================================================
  logic [15:0] lit_cnt; // Cycles the emitter has been lit so far.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lit_cnt <= 16'h0000;
    end else begin
      lit_cnt <= emitter_driver_sink ? lit_cnt + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_pin_sinks_low: assert property (irq_n_o == 1'b0)
    else $error("interrupt pin output level is not low");
  a_pulse_too_long: assert property (lit_cnt <= LED_CYC - 1)
    else $error("emitter pulse exceeds its on-time");
  a_write_answer: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready) |-> ##2 s_axi_bvalid)
    else $error("write response missing two cycles after accept");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
    else $error("write response code not OKAY");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing one cycle after accept");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  a_arready_rule: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not the inverse of rvalid");
  a_irq_kept: assert property (!irq_n_oe && !s_axi_bvalid
    && !(s_axi_wvalid && s_axi_wready) |=> !irq_n_oe)
    else $error("interrupt released without a host write");
  c_irq_fires: cover property ($fell(irq_n_oe));
  c_irq_clears: cover property ($rose(irq_n_oe));
  c_emitter_pulse: cover property ($fell(emitter_driver_sink));
endmodule

bind light_proximity_interrupt_logic sensor_props #(.LED_CYC(LED_CYC)) u_sensor_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .emitter_driver_sink, .irq_n_o, .irq_n_oe);

// [bench/test_light_proximity_interrupt_logic.sv]
module test_light_proximity_interrupt_logic;
  import sensor_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AT = 40; // Shortened ambient period, cycles.
  localparam int PT = 30; // Shortened proximity period, cycles.
  localparam int LT = 5;  // Shortened emitter window, cycles.
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, ambient_channel_active, emitter_driver_sink;
  logic        irq_n_o, irq_n_oe, irq_pin, ah, wh, dn;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, prox_adc_code, prox_set = 8'h10;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [11:0] ambient_adc_code, amb_set = 12'h150;
  int          n_mismatch = 0, n_compared = 0, c, k, hits;
  light_proximity_interrupt_logic #(.ALS_CYC(AT), .PCONV_CYC(12), .LED_CYC(LT), .PPER_CYC(PT))
    u_light_proximity_interrupt_logic (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ambient_adc_code, .prox_adc_code,
    .ambient_channel_active, .emitter_driver_sink, .irq_n_o, .irq_n_oe);
  afe_model u_afe_model (.aclk, .amb_set, .prox_set, .ambient_adc_code, .prox_adc_code,
    .irq_n_o, .irq_n_oe, .irq_pin);
  // ==========================================================================
  // Bus tasks; handshakes are judged from values settled before the edge.
  // ==========================================================================
  initial begin
    forever #10 aclk = ~aclk;
  end
  task automatic stop_test();
    $display("Counts: compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic give_up();
    n_mismatch++;
    stop_test();
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    n = 0;
    do begin
      @(negedge aclk);
      {ah, wh, dn} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 0;
      if (wh) s_axi_wvalid <= 0;
      n++;
    end while (!dn && n < 50);
    s_axi_bready <= 0;
    if (!dn) give_up();
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    n = 0;
    do begin
      @(negedge aclk);
      {ah, dn, d} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rdata};
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 0;
      n++;
    end while (!dn && n < 50);
    s_axi_rready <= 0;
    if (!dn) give_up();
  endtask
  // Counts cycles until the interrupt pin is pulled low.
  task automatic wait_low(input int bound, output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (irq_pin !== 1'b0 && n < bound);
    if (irq_pin !== 1'b0) give_up();
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    give_up();
  end
  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    chk("pin idle", 1, irq_pin);
    axr(ALS_LO_ADDR, rd);
    chk("window low", 0, rd);
    axr(ALS_HI_ADDR, rd);
    chk("window high", 32'hfff, rd);
    axr(PROX_THR_ADDR, rd);
    chk("threshold", 32'hff, rd);
    axr(STATUS_ADDR, rd);
    chk("status at reset", 32'h4, rd);
    axr(8'h1c, rd);
    chk("unmapped", 0, rd);
    axw(ALS_LO_ADDR, 32'h100);
    axw(ALS_HI_ADDR, 32'h200);
    axw(PROX_THR_ADDR, 32'h80);
    $display("Test reset values done");
    for (k = 0; k < 4; k++) begin
      axw(CTRL_ADDR, 32'h1 | (k << CTRL_PERS_LSB));
      amb_set <= 12'h150;
      repeat (2 * AT + 10) @(posedge aclk);
      axw(STATUS_ADDR, 32'h3);
      amb_set <= k[0] ? 12'h050 : 12'h300;
      wait_low(20 * AT, c);
      hits = (k == 0) ? 1 : (4 << (k - 1));
      chk("hits before pin", 1, (c > (hits - 1) * AT) && (c <= hits * AT + 8));
      axr(STATUS_ADDR, rd);
      chk("ambient flag", 1, rd[ST_ALS_BIT]);
    end
    chk("ambient active", 1, ambient_channel_active);
    axr(ALS_DATA_ADDR, rd);
    chk("ambient result", 32'h050, rd);
    axw(STATUS_ADDR, 32'h1);
    repeat (3) @(posedge aclk);
    chk("pin released", 1, irq_pin);
    $display("Test ambient window done");
    amb_set <= 12'h150;
    axw(CTRL_ADDR, 32'h3);
    axw(STATUS_ADDR, 32'h3);
    prox_set <= 8'h90;
    wait_low(3 * PT, c);
    axr(STATUS_ADDR, rd);
    chk("prox flag", 2'b10, rd[1:0]);
    c = 0;
    while (emitter_driver_sink !== 1'b1 && c < 2 * PT) begin
      @(negedge aclk);
      c++;
    end
    for (c = 0; emitter_driver_sink === 1'b1 && c < PT; c++) @(negedge aclk);
    chk("emitter on cycles", LT - 1, c);
    for (c = 0; emitter_driver_sink !== 1'b1 && c < 2 * PT; c++) @(negedge aclk);
    chk("emitter period", PT - LT + 1, c);
    $display("Test proximity done");
    prox_set <= 8'h10;
    amb_set <= 12'h300;
    axw(CTRL_ADDR, 32'h7);
    repeat (2 * AT) @(posedge aclk);
    axw(STATUS_ADDR, 32'h3);
    repeat (3 * AT) @(posedge aclk);
    chk("one-sided hits", 1, irq_pin);
    prox_set <= 8'h90;
    wait_low(3 * AT, c);
    axr(STATUS_ADDR, rd);
    chk("combined flags", 2'b11, rd[1:0]);
    $display("Test combined mode done");
    axw(CTRL_ADDR, 32'h0);
    axr(STATUS_ADDR, rd);
    chk("powered down", 1, rd[ST_PDOWN_BIT]);
    repeat (2 * PT) @(posedge aclk);
    chk("emitter dark", 0, {ambient_channel_active, emitter_driver_sink});
    $display("Test power down done");
    stop_test();
  end
endmodule

// [common/sensor_pkg.sv]
package sensor_pkg;

  // ==========================================================================
  // Register map (byte addresses on the AXI4-Lite slave).
  // ==========================================================================
  localparam logic [7:0] CTRL_ADDR      = 8'h00; // Enables, persistence, combined mode.
  localparam logic [7:0] ALS_LO_ADDR    = 8'h04; // Ambient window lower limit.
  localparam logic [7:0] ALS_HI_ADDR    = 8'h08; // Ambient window upper limit.
  localparam logic [7:0] PROX_THR_ADDR  = 8'h0c; // Proximity threshold.
  localparam logic [7:0] STATUS_ADDR    = 8'h10; // Flags; write one to clear.
  localparam logic [7:0] ALS_DATA_ADDR  = 8'h14; // Last ambient result.
  localparam logic [7:0] PROX_DATA_ADDR = 8'h18; // Last proximity result.

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int CTRL_AMBIENT_CHANNEL_ENABLE_BIT  = 0;
  localparam int CTRL_PROX_EN_BIT = 1;
  localparam int CTRL_COMB_BIT    = 2;
  localparam int CTRL_PERS_LSB    = 4;
  localparam int ST_ALS_BIT       = 0;
  localparam int ST_PROX_BIT      = 1;
  localparam int ST_PDOWN_BIT     = 2;

  // ==========================================================================
  // Widths and reset values.
  // ==========================================================================
  localparam int ALS_W  = 12;
  localparam int PROX_W = 8;
  localparam logic [11:0] ALS_LO_RST   = 12'h000;
  localparam logic [11:0] ALS_HI_RST   = 12'hfff;
  localparam logic [7:0]  PROX_THR_RST = 8'hff;

  // Persistence selector codes: 1, 4, 8 or 16 consecutive hits.
  typedef enum logic [1:0] {
    PERS_1  = 2'b00,
    PERS_4  = 2'b01,
    PERS_8  = 2'b10,
    PERS_16 = 2'b11
  } pers_t;

  // ==========================================================================
  // Timing.
  // ==========================================================================
  localparam longint CLK_HZ          = 50000000;
  localparam longint ALS_PERIOD_MS   = 100;
  localparam longint PROX_CONV_US    = 547;
  localparam longint LED_ON_US       = 100;
  localparam longint PROX_PERIOD_MS  = 800;
  localparam longint ALS_PERIOD_CYC  = ALS_PERIOD_MS * CLK_HZ / 1000;
  localparam longint PROX_CONV_CYC   = PROX_CONV_US * CLK_HZ / 1000000;
  localparam longint LED_ON_CYC      = LED_ON_US * CLK_HZ / 1000000;
  localparam longint PROX_PERIOD_CYC = PROX_PERIOD_MS * CLK_HZ / 1000;

endpackage

// [core/light_proximity_interrupt_logic.sv]
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
module light_proximity_interrupt_logic
  import sensor_pkg::*;
#(
  parameter longint ALS_CYC   = ALS_PERIOD_CYC,
  parameter longint PCONV_CYC = PROX_CONV_CYC,
  parameter longint LED_CYC   = LED_ON_CYC,
  parameter longint PPER_CYC  = PROX_PERIOD_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [ALS_W-1:0]  ambient_adc_code,
  input  wire logic [PROX_W-1:0] prox_adc_code,
  output logic                   ambient_channel_active,
  output logic                   emitter_driver_sink,
  output logic                   irq_n_o,
  output logic                   irq_n_oe
);

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  // Number of consecutive hits that the persistence code demands.
  function automatic logic [4:0] pers_count(input logic [1:0] code);
    unique case (pers_t'(code))
      PERS_1:  pers_count = 5'd1;
      PERS_4:  pers_count = 5'd4;
      PERS_8:  pers_count = 5'd8;
      PERS_16: pers_count = 5'd16;
    endcase
  endfunction

  // Byte-lane merge for a 32-bit register write.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ==========================================================================
  // Input synchronisers (converter codes arrive from the analog domain).
  // ==========================================================================
  logic [ALS_W-1:0]  als_s1_reg, als_s2_reg;   // Ambient code sync stages.
  logic [PROX_W-1:0] prox_s1_reg, prox_s2_reg; // Proximity code sync stages.

  // Two flops on each converter code input; only the second stage is read.
  always_ff @(posedge aclk) begin
    als_s1_reg  <= ambient_adc_code;
    als_s2_reg  <= als_s1_reg;
    prox_s1_reg <= prox_adc_code;
    prox_s2_reg <= prox_s1_reg;
  end

  // ==========================================================================
  // Registers.
  // ==========================================================================
  logic [31:0]       ctrl_reg;      // Control word.
  logic [ALS_W-1:0]  als_lo_reg;    // Window lower limit.
  logic [ALS_W-1:0]  als_hi_reg;    // Window upper limit.
  logic [PROX_W-1:0] prox_thr_reg;  // Proximity threshold.
  logic [ALS_W-1:0]  als_data_reg;  // Latest ambient result.
  logic [PROX_W-1:0] prox_data_reg; // Latest proximity result.
  logic              als_flag_reg;  // Sticky ambient event flag.
  logic              prox_flag_reg; // Sticky proximity event flag.

  logic ambient_channel_enable, prox_en, comb_mode, powered_down;
  assign ambient_channel_enable       = ctrl_reg[CTRL_AMBIENT_CHANNEL_ENABLE_BIT];
  assign prox_en      = ctrl_reg[CTRL_PROX_EN_BIT];
  assign comb_mode    = ctrl_reg[CTRL_COMB_BIT];
  assign powered_down = !ambient_channel_enable && !prox_en;

  // ==========================================================================
  // AXI4-Lite write channel: address and data taken in either order.
  // ==========================================================================
  logic       aw_have_reg, w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic       wr_fire;

  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  assign wr_fire       = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign s_axi_bresp   = 2'b00;

  // Capture address and data, then answer once both are held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration writes; unmapped addresses are accepted and ignored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= 32'h0000_0000;
      als_lo_reg   <= ALS_LO_RST;
      als_hi_reg   <= ALS_HI_RST;
      prox_thr_reg <= PROX_THR_RST;
    end else if (wr_fire) begin
      unique case (aw_addr_reg)
        CTRL_ADDR:     ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & 32'h0000_0037;
        ALS_LO_ADDR:   als_lo_reg <= 12'(merge({20'h0, als_lo_reg}, w_data_reg, w_strb_reg));
        ALS_HI_ADDR:   als_hi_reg <= 12'(merge({20'h0, als_hi_reg}, w_data_reg, w_strb_reg));
        PROX_THR_ADDR: prox_thr_reg <= 8'(merge({24'h0, prox_thr_reg}, w_data_reg, w_strb_reg));
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel.
  // ==========================================================================
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp   = 2'b00;

  // Read data registered one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      unique case (s_axi_araddr)
        CTRL_ADDR:      s_axi_rdata <= ctrl_reg;
        ALS_LO_ADDR:    s_axi_rdata <= {20'h0, als_lo_reg};
        ALS_HI_ADDR:    s_axi_rdata <= {20'h0, als_hi_reg};
        PROX_THR_ADDR:  s_axi_rdata <= {24'h0, prox_thr_reg};
        STATUS_ADDR:    s_axi_rdata <= {29'h0, powered_down, prox_flag_reg, als_flag_reg};
        ALS_DATA_ADDR:  s_axi_rdata <= {20'h0, als_data_reg};
        PROX_DATA_ADDR: s_axi_rdata <= {24'h0, prox_data_reg};
        default:        s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Ambient channel sequencer.
  // ==========================================================================
  logic [31:0] als_cnt_reg; // Cycles into the current ambient sample period.
  logic        als_done;    // Pulse: an ambient result completes.

  assign als_done               = ambient_channel_enable && (als_cnt_reg == 32'(ALS_CYC - 1));
  assign ambient_channel_active = ambient_channel_enable;

  // Free-running sample period while enabled; restarts when disabled.
  always_ff @(posedge aclk) begin
    if (!aresetn || !ambient_channel_enable || als_done) begin
      als_cnt_reg <= 32'h0000_0000;
    end else begin
      als_cnt_reg <= als_cnt_reg + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // Proximity channel sequencer, independent of the ambient one.
  // ==========================================================================
  logic [31:0] prox_cnt_reg; // Cycles into the current proximity period.
  logic        prox_done;    // Pulse: a proximity result completes.

  assign prox_done = prox_en && (prox_cnt_reg == 32'(PCONV_CYC - 1));

  // Period restarts on its own; the ambient counter never stalls it.
  always_ff @(posedge aclk) begin
    if (!aresetn || !prox_en || prox_cnt_reg == 32'(PPER_CYC - 1)) begin
      prox_cnt_reg <= 32'h0000_0000;
    end else begin
      prox_cnt_reg <= prox_cnt_reg + 32'h0000_0001;
    end
  end

  // Emitter is lit for the first part of each conversion only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emitter_driver_sink <= 1'b0;
    end else begin
      emitter_driver_sink <= prox_en && (prox_cnt_reg < 32'(LED_CYC - 1));
    end
  end

  // ==========================================================================
  // Result capture and trigger evaluation.
  // ==========================================================================
  logic als_hit, prox_hit;
  assign als_hit  = (als_s2_reg < als_lo_reg) || (als_s2_reg > als_hi_reg);
  assign prox_hit = prox_s2_reg > prox_thr_reg;

  // Latch each completed result.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      als_data_reg  <= '0;
      prox_data_reg <= '0;
    end else begin
      if (als_done) als_data_reg <= als_s2_reg;
      if (prox_done) prox_data_reg <= prox_s2_reg;
    end
  end

  // Latest trigger state of each channel, used by combined mode.
  logic als_trig_reg, prox_trig_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || !ambient_channel_enable) als_trig_reg <= 1'b0;
    else if (als_done) als_trig_reg <= als_hit;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !prox_en) prox_trig_reg <= 1'b0;
    else if (prox_done) prox_trig_reg <= prox_hit;
  end

  // ==========================================================================
  // Persistence filters.
  // ==========================================================================
  logic [4:0] als_run_reg, prox_run_reg; // Consecutive-hit counters.
  logic [4:0] need;
  logic       comb_eval;                 // Combined mode evaluates on ambient or proximity results.
  logic       als_step, prox_step;
  assign need      = pers_count(ctrl_reg[CTRL_PERS_LSB +: 2]);
  assign comb_eval = comb_mode && (als_done || prox_done);
  assign als_step  = comb_mode ? comb_eval : als_done;
  assign prox_step = !comb_mode && prox_done;

  // Ambient (or combined) run counter; a miss restarts the run.
  always_ff @(posedge aclk) begin
    if (!aresetn || powered_down) begin
      als_run_reg <= 5'd0;
    end else if (als_step) begin
      if (comb_mode ? ((als_done ? als_hit : als_trig_reg) &&
                       (prox_done ? prox_hit : prox_trig_reg))
                    : als_hit) begin
        als_run_reg <= (als_run_reg >= need) ? need : als_run_reg + 5'd1;
      end else begin
        als_run_reg <= 5'd0;
      end
    end
  end

  // Proximity run counter in independent mode.
  always_ff @(posedge aclk) begin
    if (!aresetn || powered_down || comb_mode) begin
      prox_run_reg <= 5'd0;
    end else if (prox_step) begin
      prox_run_reg <= prox_hit ? ((prox_run_reg >= need) ? need : prox_run_reg + 5'd1)
                               : 5'd0;
    end
  end

  logic als_fire, prox_fire;
  assign als_fire  = als_step && (als_run_reg + 5'd1 == need) &&
                     (comb_mode ? ((als_done ? als_hit : als_trig_reg) &&
                                   (prox_done ? prox_hit : prox_trig_reg)) : als_hit);
  assign prox_fire = prox_step && prox_hit && (prox_run_reg + 5'd1 == need);

  // ==========================================================================
  // Sticky flags: a new event wins over a same-cycle clear.
  // ==========================================================================
  logic st_wr;
  assign st_wr = wr_fire && (aw_addr_reg == STATUS_ADDR) && w_strb_reg[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      als_flag_reg  <= 1'b0;
      prox_flag_reg <= 1'b0;
    end else begin
      if (als_fire) als_flag_reg <= 1'b1;
      else if (st_wr && w_data_reg[ST_ALS_BIT]) als_flag_reg <= 1'b0;
      if (prox_fire || (als_fire && comb_mode)) prox_flag_reg <= 1'b1;
      else if (st_wr && w_data_reg[ST_PROX_BIT]) prox_flag_reg <= 1'b0;
    end
  end

  // Open-drain pin: output held low, enable low pulls the line.
  assign irq_n_o  = 1'b0;
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_n_oe <= 1'b1;
    else irq_n_oe <= !(als_flag_reg || prox_flag_reg);
  end

endmodule
